// ===== fsb_host_agent.sv
// Purpose: chipset-side agent driving the processor address/arbitration pins
// Assumes: pins sampled through two flops; plain command port, read data next cycle
// Notes:   one request at a time; address lines also carry reset-time straps
//
// Contract
// - Address lines carry address with strobe
// - High parity A35:24, low A23:3
// - Parity high for even low count
// - Parity driven with strobe and request
// - Strobe starts checks of new transaction
// - Enabled parity error aborts transaction
// - All on rising clock edge
// - Assert bus init on unreliable bus
// - Bus init resets bus state machines
// - No new transaction during stall
// - Stall driven, sampled on designated edges
// - Priority held until requests complete
// - Assert symmetric request during reset config
// - Speed select 00/01/11, 10 reserved
// - Mobile variant runs at 100 MHz
//
// The strobed register port and the register addresses were left to the implementer.
`default_nettype none
module fsb_host_agent #(
  parameter int CfgCycles = fsb_pkg::CFG_CYCLES,
  parameter int PriSettle = fsb_pkg::PRI_SETTLE,
  parameter int AerrWin   = fsb_pkg::ADDR_PARITY_ERROR_WIN
) (
  input  wire logic                    core_clk,
  input  wire logic                    nrst,
  input  wire logic [3:0]              regAddr,
  input  wire logic [31:0]             regWData,
  input  wire logic                    regWr,
  input  wire logic                    regRd,
  output logic      [31:0]             regRData,
  input  wire fsb_pkg::fsb_pin_in_type pinIn,
  output fsb_pkg::fsb_pin_out_type     pinOut
);
  if (CfgCycles < 1 || CfgCycles > 65535 || PriSettle < 1 || PriSettle > 65535 ||
      AerrWin < 1 || AerrWin > 65535) begin : g_chk
    $error("fsb_host_agent: cycle counts must lie in 1..65535");
  end

  fsb_pkg::fsb_pin_in_type  pinMeta_r;
  fsb_pkg::fsb_pin_in_type  pinSync_r;
  fsb_pkg::fsb_pin_out_type out_nxt;
  fsb_pkg::fsb_state_type   state_r;
  fsb_pkg::fsb_state_type   state_nxt;
  fsb_pkg::fsb_status_type  stat;
  logic [32:0] addr_r;
  logic [32:0] addr_nxt;
  logic [4:0]  req_r;
  logic [4:0]  req_nxt;
  logic [7:0]  ctrl_r;
  logic [7:0]  ctrl_nxt;
  logic [31:0] strap_r;
  logic [31:0] strap_nxt;
  logic [1:0]  speed_r;
  logic [1:0]  speed_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [32:0] inAddr_r;
  logic [32:0] inAddr_nxt;
  logic [3:0]  bp_r;
  logic [3:0]  bp_nxt;
  logic [1:0]  ownDly_r;
  logic [31:0] rdata_nxt;
  logic        pending_r;
  logic        pending_nxt;
  logic        phase_r;
  logic        phase_nxt;
  logic        stall_r;
  logic        stall_nxt;
  logic        aborted_r;
  logic        aborted_nxt;
  logic        inParErr_r;
  logic        inParErr_nxt;
  logic        symSeen_r;
  logic        symSeen_nxt;
  logic        launch;
  logic        inValid;
  logic        inParEv;
  logic        binitSeen;
  logic        cfgPhase;

  // Two-flop pin synchroniser; first stage feeds only the second
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pinMeta_r <= '1;
      pinSync_r <= '1;
    end else begin
      pinMeta_r <= pinIn;
      pinSync_r <= pinMeta_r;
    end
  end

  // Next-state logic for the agent, apart from the synchroniser and ownDly_r
  always_comb begin
    state_nxt    = state_r;
    out_nxt      = pinOut;
    addr_nxt     = addr_r;
    req_nxt      = req_r;
    ctrl_nxt     = ctrl_r;
    strap_nxt    = strap_r;
    speed_nxt    = speed_r;
    cnt_nxt      = cnt_r;
    inAddr_nxt   = inAddr_r;
    pending_nxt  = pending_r;
    aborted_nxt  = aborted_r;
    inParErr_nxt = inParErr_r;
    launch       = 1'b0;
    cfgPhase     = (state_r == fsb_pkg::ST_CFG) || (state_r == fsb_pkg::ST_REL);
    binitSeen    = ctrl_r[fsb_pkg::CTL_BUS_INITIALISE_EN] && !pinSync_r.binitN;
    // Own strobe echo is delayed like the synchroniser, so it is not checked
    inValid      = !pinSync_r.adsN && !ownDly_r[1] && !cfgPhase;
    inParEv      = inValid && (pinSync_r.parN !=
                   {fsb_pkg::lvlPar({21'h1FFFFF, pinSync_r.addrN[32:21]}),
                    fsb_pkg::lvlPar({12'hFFF, pinSync_r.addrN[20:0]})});
    phase_nxt    = ~phase_r;
    stall_nxt    = phase_r ? !pinSync_r.bnrN : stall_r;
    bp_nxt       = ~{pinSync_r.bpN, pinSync_r.bpmN};
    symSeen_nxt  = !pinSync_r.symReqN && !cfgPhase;
    out_nxt.aerrOe  = 1'b0;
    out_nxt.binitOe = 1'b0;
    out_nxt.wrapMaskN = ~ctrl_r[fsb_pkg::CTL_WRAP];
    out_nxt.speedSel = speed_r;

    case (state_r)
      fsb_pkg::ST_CFG: begin
        out_nxt.cpuResetN = 1'b0;
        out_nxt.addrOe    = 1'b1;
        out_nxt.addrN     = ~{1'b0, strap_r};
        out_nxt.symReqOe  = 1'b1;
        out_nxt.symReqN   = 1'b0;
        cnt_nxt           = cnt_r + 16'h1;
        if (cnt_r >= 16'(CfgCycles - 1)) begin
          out_nxt.cpuResetN = 1'b1;
          state_nxt         = fsb_pkg::ST_REL;
        end
      end
      fsb_pkg::ST_REL: begin
        // Straps held one edge past release so the transition sees them
        out_nxt.addrOe   = 1'b0;
        out_nxt.symReqOe = 1'b0;
        out_nxt.symReqN  = 1'b1;
        cnt_nxt          = 16'h0;
        state_nxt        = fsb_pkg::ST_IDLE;
      end
      fsb_pkg::ST_IDLE: begin
        cnt_nxt = 16'h0;
        if (pending_r && !stall_r) begin
          if (ctrl_r[fsb_pkg::CTL_PRI]) begin
            out_nxt.priReqN = 1'b0;
            state_nxt       = fsb_pkg::ST_PRI;
          end else begin
            launch = 1'b1;
          end
        end
      end
      fsb_pkg::ST_PRI: begin
        cnt_nxt = cnt_r + 16'h1;
        if (cnt_r >= 16'(PriSettle - 1) && !stall_r) begin
          launch = 1'b1;
        end
      end
      fsb_pkg::ST_ADS: begin
        out_nxt.adsN   = 1'b1;
        out_nxt.adsOe  = 1'b0;
        out_nxt.addrOe = 1'b0;
        out_nxt.reqN   = '1;
        cnt_nxt        = 16'h0;
        state_nxt      = fsb_pkg::ST_WAIT;
      end
      default: begin
        cnt_nxt = cnt_r + 16'h1;
        // observed error ends the wait even with the sticky flag already set
        if ((ctrl_r[fsb_pkg::CTL_ADDR_PARITY_ERROR_OBS] && !pinSync_r.aerrN) ||
            cnt_r >= 16'(AerrWin - 1)) begin
          out_nxt.priReqN = pending_r ? pinOut.priReqN : 1'b1;
          state_nxt       = fsb_pkg::ST_IDLE;
        end
      end
    endcase

    // Launch drives the whole request group in one cycle
    if (launch) begin
      out_nxt.addrN   = ~addr_r;
      out_nxt.addrOe  = 1'b1;
      out_nxt.adsN    = 1'b0;
      out_nxt.adsOe   = 1'b1;
      out_nxt.reqN    = ~req_r;
      out_nxt.parN[1] = fsb_pkg::lvlPar({21'h1FFFFF, ~addr_r[32:21]});
      out_nxt.parN[0] = fsb_pkg::lvlPar({12'hFFF, ~addr_r[20:0]});
      out_nxt.reqParN = fsb_pkg::lvlPar({28'hFFFFFFF, ~req_r});
      pending_nxt     = 1'b0;
      cnt_nxt         = 16'h0;
      state_nxt       = fsb_pkg::ST_ADS;
    end

    // Register writes; reserved speed code is ignored
    if (regWr) begin
      if (regAddr == fsb_pkg::REG_ADDR_LO) begin
        addr_nxt[28:0] = regWData[31:3];
      end else if (regAddr == fsb_pkg::REG_ADDR_HI) begin
        addr_nxt[32:29] = regWData[3:0];
        req_nxt         = regWData[fsb_pkg::HI_REQ +: 5];
      end else if (regAddr == fsb_pkg::REG_CTRL) begin
        ctrl_nxt = regWData[7:0];
        if (regWData[fsb_pkg::CTL_SPEED +: 2] != fsb_pkg::SPD_RSV) begin
          speed_nxt = regWData[fsb_pkg::CTL_SPEED +: 2];
        end
      end else if (regAddr == fsb_pkg::REG_STRAP) begin
        strap_nxt = regWData;
      end else if (regAddr == fsb_pkg::REG_CMD) begin
        if (regWData[fsb_pkg::CMD_GO]) begin
          pending_nxt = 1'b1;
        end
        if (regWData[fsb_pkg::CMD_CLEAR]) begin
          aborted_nxt  = 1'b0;
          inParErr_nxt = 1'b0;
        end
        if (regWData[fsb_pkg::CMD_RESTART] && state_r == fsb_pkg::ST_IDLE && !pending_r) begin
          cnt_nxt   = 16'h0;
          state_nxt = fsb_pkg::ST_CFG;
        end
      end
    end

    if (inValid) begin
      inAddr_nxt = ~pinSync_r.addrN;
    end
    // Event sets come after the clear so a same-cycle event wins
    if (inParEv) begin
      inParErr_nxt = 1'b1;
    end
    if (state_r == fsb_pkg::ST_WAIT && ctrl_r[fsb_pkg::CTL_ADDR_PARITY_ERROR_OBS] && !pinSync_r.aerrN) begin
      aborted_nxt = 1'b1;
    end
    out_nxt.aerrOe = inParEv;
    out_nxt.binitOe = ctrl_r[fsb_pkg::CTL_BUS_INITIALISE_EN] &&
                      ((regWr && regAddr == fsb_pkg::REG_CMD && regWData[fsb_pkg::CMD_BUS_INITIALISE]) ||
                       (inParEv && !ctrl_r[fsb_pkg::CTL_ADDR_PARITY_ERROR_OBS]));
    if (!phase_r) begin
      out_nxt.bnrOe = ctrl_r[fsb_pkg::CTL_NOT_READY];
    end

    if (binitSeen && !cfgPhase) begin
      state_nxt       = fsb_pkg::ST_IDLE;
      pending_nxt     = 1'b0;
      cnt_nxt         = 16'h0;
      phase_nxt       = 1'b0;
      stall_nxt       = 1'b0;
      out_nxt.adsN    = 1'b1;
      out_nxt.adsOe   = 1'b0;
      out_nxt.addrOe  = 1'b0;
      out_nxt.reqN    = '1;
      out_nxt.priReqN = 1'b1;
    end

    // Read data in the cycle after the strobe, zero elsewhere
    stat          = '0;
    stat.bp       = bp_r;
    stat.symSeen  = symSeen_r;
    stat.inParErr = inParErr_r;
    stat.aborted  = aborted_r;
    stat.stall    = stall_r;
    stat.pending  = pending_r;
    stat.busy     = state_r != fsb_pkg::ST_IDLE;
    rdata_nxt     = 32'h0;
    if (regRd) begin
      if (regAddr == fsb_pkg::REG_ADDR_LO) begin
        rdata_nxt = {addr_r[28:0], 3'h0};
      end else if (regAddr == fsb_pkg::REG_ADDR_HI) begin
        rdata_nxt = {19'h0, req_r, 4'h0, addr_r[32:29]};
      end else if (regAddr == fsb_pkg::REG_CTRL) begin
        rdata_nxt = {22'h0, speed_r, ctrl_r};
      end else if (regAddr == fsb_pkg::REG_STATUS) begin
        rdata_nxt = stat;
      end else if (regAddr == fsb_pkg::REG_IN_ADDR) begin
        rdata_nxt = {inAddr_r[28:0], 3'h0};
      end else if (regAddr == fsb_pkg::REG_STRAP) begin
        rdata_nxt = strap_r;
      end
    end
  end

  // State registers
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_r    <= fsb_pkg::ST_CFG;
      pinOut     <= fsb_pkg::PIN_OUT_RST;
      addr_r     <= 33'h0;
      req_r      <= 5'h0;
      ctrl_r     <= fsb_pkg::CTRL_RST;
      strap_r    <= fsb_pkg::STRAP_RST;
      speed_r    <= fsb_pkg::SPD_100;
      cnt_r      <= 16'h0;
      inAddr_r   <= 33'h0;
      bp_r       <= 4'h0;
      ownDly_r   <= 2'h0;
      regRData   <= 32'h0;
      pending_r  <= 1'b0;
      phase_r    <= 1'b0;
      stall_r    <= 1'b0;
      aborted_r  <= 1'b0;
      inParErr_r <= 1'b0;
      symSeen_r  <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      pinOut     <= out_nxt;
      addr_r     <= addr_nxt;
      req_r      <= req_nxt;
      ctrl_r     <= ctrl_nxt;
      strap_r    <= strap_nxt;
      speed_r    <= speed_nxt;
      cnt_r      <= cnt_nxt;
      inAddr_r   <= inAddr_nxt;
      bp_r       <= bp_nxt;
      ownDly_r   <= {ownDly_r[0], pinOut.adsOe};
      regRData   <= rdata_nxt;
      pending_r  <= pending_nxt;
      phase_r    <= phase_nxt;
      stall_r    <= stall_nxt;
      aborted_r  <= aborted_nxt;
      inParErr_r <= inParErr_nxt;
      symSeen_r  <= symSeen_nxt;
    end
  end

  // Checks on driven pins and agent state
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  a_par_high: assert property (pinOut.adsOe |-> pinOut.parN[1] ==
    fsb_pkg::lvlPar({21'h1FFFFF, pinOut.addrN[32:21]}))
    else $error("high address parity wrong");
  a_par_low: assert property (pinOut.adsOe |-> pinOut.parN[0] ==
    fsb_pkg::lvlPar({12'hFFF, pinOut.addrN[20:0]}))
    else $error("low address parity wrong");
  a_ads_group: assert property ($rose(pinOut.adsOe) |-> pinOut.addrOe && !pinOut.adsN &&
    pinOut.reqParN == fsb_pkg::lvlPar({28'hFFFFFFF, pinOut.reqN}) ##1 !pinOut.adsOe)
    else $error("request group not driven for one cycle");
  a_stall_block: assert property (stall_r && (state_r == fsb_pkg::ST_IDLE ||
    state_r == fsb_pkg::ST_PRI) |=> !pinOut.adsOe)
    else $error("strobe issued during stall");
  a_bnr_edge: assert property ($changed(pinOut.bnrOe) |-> !$past(phase_r))
    else $error("stall drive changed off its edge");
  a_cfg_release: assert property (state_r == fsb_pkg::ST_REL |-> pinOut.cpuResetN &&
    pinOut.symReqOe && !pinOut.symReqN && pinOut.addrOe)
    else $error("config not held across reset release");
  a_pri_release: assert property ($rose(pinOut.priReqN) |-> ($past(state_r) ==
    fsb_pkg::ST_WAIT && !$past(pending_r)) || $past(binitSeen))
    else $error("priority released with work pending");
  a_addr_parity_error_abort: assert property (state_r == fsb_pkg::ST_WAIT && ctrl_r[fsb_pkg::CTL_ADDR_PARITY_ERROR_OBS]
    && !pinSync_r.aerrN |=> aborted_r && state_r == fsb_pkg::ST_IDLE)
    else $error("parity error did not abort");
  a_bus_initialise_reset: assert property (binitSeen && state_r != fsb_pkg::ST_CFG &&
    state_r != fsb_pkg::ST_REL |=> state_r == fsb_pkg::ST_IDLE && !pending_r &&
    pinOut.priReqN)
    else $error("bus init did not reset agent");
  a_speed_valid: assert property (pinOut.speedSel != fsb_pkg::SPD_RSV)
    else $error("reserved speed code driven");

  c_issue: cover property ($rose(pinOut.adsOe));
  c_abort: cover property ($rose(aborted_r));
  c_bus_initialise: cover property (binitSeen && state_r == fsb_pkg::ST_WAIT);
  c_stall_wait: cover property (pending_r && stall_r ##1 pending_r);
endmodule
`default_nettype wire

// ===== fsb_pkg.sv
// Purpose: constants, pin groups and states for the front-side bus host agent
// Assumes: one 100 MHz clock; pin levels are raw, a trailing N marks active low
// Notes:   register indices are word addresses on the plain command port
`default_nettype none
package fsb_pkg;
  // Timing
  localparam int CLK_NS      = 10;
  localparam int CFG_HOLD_NS = 1000;
  localparam int CFG_CYCLES  = (CFG_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int PRI_SETTLE  = 2;
  localparam int ADDR_PARITY_ERROR_WIN    = 4;
  // Register indices
  localparam logic [3:0] REG_ADDR_LO = 4'h0;
  localparam logic [3:0] REG_ADDR_HI = 4'h1;
  localparam logic [3:0] REG_CTRL    = 4'h2;
  localparam logic [3:0] REG_CMD     = 4'h3;
  localparam logic [3:0] REG_STATUS  = 4'h4;
  localparam logic [3:0] REG_IN_ADDR = 4'h5;
  localparam logic [3:0] REG_STRAP   = 4'h6;
  // Field positions
  localparam int HI_REQ        = 8;
  localparam int CTL_ADDR_PARITY_ERROR_OBS  = 0;
  localparam int CTL_BUS_INITIALISE_EN  = 1;
  localparam int CTL_PRI       = 2;
  localparam int CTL_NOT_READY = 3;
  localparam int CTL_WRAP      = 4;
  localparam int CTL_SPEED     = 8;
  localparam int CMD_GO        = 0;
  localparam int CMD_BUS_INITIALISE     = 1;
  localparam int CMD_RESTART   = 2;
  localparam int CMD_CLEAR     = 3;
  // Reset values
  localparam logic [7:0]  CTRL_RST  = 8'h03;
  localparam logic [31:0] STRAP_RST = 32'h0;
  // Bus speed codes
  localparam logic [1:0] SPD_66  = 2'h0;
  localparam logic [1:0] SPD_100 = 2'h1;
  localparam logic [1:0] SPD_RSV = 2'h2;
  localparam logic [1:0] SPD_133 = 2'h3;

  typedef enum logic [2:0] {ST_CFG, ST_REL, ST_IDLE, ST_PRI, ST_ADS, ST_WAIT} fsb_state_type;

  typedef struct packed {
    logic [32:0] addrN;
    logic        addrOe;
    logic        adsN;
    logic        adsOe;
    logic [1:0]  parN;
    logic [4:0]  reqN;
    logic        reqParN;
    logic        aerrN;
    logic        aerrOe;
    logic        bnrN;
    logic        bnrOe;
    logic        binitN;
    logic        binitOe;
    logic        symReqN;
    logic        symReqOe;
    logic        priReqN;
    logic        wrapMaskN;
    logic [1:0]  speedSel;
    logic        cpuResetN;
  } fsb_pin_out_type;

  typedef struct packed {
    logic [32:0] addrN;
    logic        adsN;
    logic [1:0]  parN;
    logic        aerrN;
    logic        bnrN;
    logic        binitN;
    logic        symReqN;
    logic [1:0]  bpN;
    logic [1:0]  bpmN;
  } fsb_pin_in_type;

  typedef struct packed {
    logic [21:0] rsvd;
    logic [3:0]  bp;
    logic        symSeen;
    logic        inParErr;
    logic        aborted;
    logic        stall;
    logic        pending;
    logic        busy;
  } fsb_status_type;

  localparam fsb_pin_out_type PIN_OUT_RST = '{addrOe: 1'b0, adsOe: 1'b0, aerrN: 1'b0,
    aerrOe: 1'b0, bnrN: 1'b0, bnrOe: 1'b0, binitN: 1'b0, binitOe: 1'b0, symReqOe: 1'b0,
    speedSel: SPD_100, cpuResetN: 1'b0, default: '1};

  // Parity level: high when an even number of the levels are low
  function automatic logic lvlPar(input logic [32:0] lvl);
    return ~^(~lvl);
  endfunction
endpackage
`default_nettype wire

// ===== fsb_cpu_model.sv
// Purpose: behavioural processor on the far side of the host agent
// Assumes: released lines float high; the bench resolves the wired lines
// Notes:   one request per issue pulse; host requests are captured on its strobe
`default_nettype none
module fsb_cpu_model (
  input  wire logic                     core_clk,
  input  wire fsb_pkg::fsb_pin_out_type host,
  input  wire fsb_pkg::fsb_pin_in_type  bus,
  input  wire logic                     issue,
  input  wire logic [32:0]              reqAddr,
  input  wire logic                     badPar,
  input  wire logic                     stallOn,
  input  wire logic                     aerrOnHost,
  input  wire logic [3:0]               bpSet,
  output var  fsb_pkg::fsb_pin_in_type  drv,
  output var  logic [32:0]              cfgAddr,
  output var  logic                     cfgSym,
  output var  logic [32:0]              seenAddr,
  output var  logic [8:0]               seenMisc,
  output var  logic [7:0]               adsCount,
  output var  logic [7:0]               aerrSeen,
  output var  logic [7:0]               binitSeen
);
  logic        prevRst;
  logic        pend;
  logic        adsAct;
  logic [32:0] lvl;

  // High when an even number of levels are low
  function automatic logic evenLow(input logic [32:0] l);
    return ~^(~l);
  endfunction

  // wrap mask clears A20 before the bus
  always_comb begin
    lvl = ~reqAddr;
    if (!host.wrapMaskN) begin
      lvl[17] = 1'b1;
    end
  end

  // Quiet bus until the first edge
  initial begin
    drv       = '1;
    prevRst   = 1'b0;
    pend      = 1'b0;
    adsAct    = 1'b0;
    cfgAddr   = '0;
    cfgSym    = 1'b0;
    seenAddr  = '0;
    seenMisc  = '0;
    adsCount  = 8'h00;
    aerrSeen  = 8'h00;
    binitSeen = 8'h00;
  end

  // everything moves on the rising edge
  always @(posedge core_clk) begin
    prevRst <= host.cpuResetN;
    // straps and request line taken on reset release
    if (!prevRst && host.cpuResetN) begin
      cfgAddr <= ~bus.addrN;
      cfgSym  <= ~bus.symReqN;
    end
    drv.bpN  <= ~bpSet[3:2];
    drv.bpmN <= ~bpSet[1:0];
    // stall level changes only at edges
    drv.bnrN    <= ~stallOn;
    // ask for ownership while a request waits
    drv.symReqN <= ~pend;
    if (issue) begin
      pend <= 1'b1;
    end
    // one strobe cycle, held off by stall and priority
    if (adsAct) begin
      drv.adsN  <= 1'b1;
      drv.addrN <= '1;
      drv.parN  <= 2'h3;
      adsAct    <= 1'b0;
    end else if (pend && host.cpuResetN && host.priReqN && bus.bnrN) begin
      drv.adsN  <= 1'b0;
      drv.addrN <= lvl;
      drv.parN  <= {evenLow({21'h1FFFFF, lvl[32:21]}), evenLow({12'hFFF, lvl[20:0]}) ^ badPar};
      adsAct    <= 1'b1;
      pend      <= 1'b0;
    end
    // bus init drops the waiting request
    if (!bus.binitN) begin
      pend      <= 1'b0;
      binitSeen <= binitSeen + 8'h01;
    end
    // parity error pulses counted off the wire
    if (!bus.aerrN) begin
      aerrSeen <= aerrSeen + 8'h01;
    end
    // host strobe starts our checks; the error answer comes from aerrOnHost
    drv.aerrN <= 1'b1;
    if (host.adsOe && !host.adsN) begin
      seenAddr  <= ~host.addrN;
      seenMisc  <= {host.priReqN, host.parN, host.reqParN, host.reqN};
      adsCount  <= adsCount + 8'h01;
      drv.aerrN <= ~aerrOnHost;
    end
  end
endmodule
`default_nettype wire

// ===== fsb_host_agent_bench.sv
// Purpose: self-checking bench for the host agent against a processor model
// Assumes: short config phase of 4 cycles; wired lines pulled high
// Notes:   expectations come from the register map and pin rules only
`default_nettype none
module fsb_host_agent_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     core_clk, nrst, regWr, regRd, issue, badPar, stallOn, aerrOnHost;
  logic [3:0]               regAddr, bpSet;
  logic [31:0]              regWData, regRData, st;
  logic [32:0]              reqAddr, cfgAddr, seenAddr, expA;
  logic                     cfgSym;
  logic [8:0]               seenMisc;
  logic [7:0]               adsCount, aerrSeen, binitSeen, c, aS, bS;
  logic [1:0]               spd [3];
  fsb_pkg::fsb_pin_out_type pinOut;
  fsb_pkg::fsb_pin_in_type  pinIn, drv;
  int                       n_mismatch, checked;

  // Wired lines: a released driver floats high
  always_comb begin
    pinIn         = drv;
    pinIn.addrN   = (pinOut.addrOe ? pinOut.addrN : '1) & drv.addrN;
    pinIn.adsN    = (pinOut.adsOe ? pinOut.adsN : 1'b1) & drv.adsN;
    pinIn.parN    = (pinOut.adsOe ? pinOut.parN : 2'h3) & drv.parN;
    pinIn.aerrN   = (pinOut.aerrOe ? pinOut.aerrN : 1'b1) & drv.aerrN;
    pinIn.bnrN    = (pinOut.bnrOe ? pinOut.bnrN : 1'b1) & drv.bnrN;
    pinIn.binitN  = (pinOut.binitOe ? pinOut.binitN : 1'b1) & drv.binitN;
    pinIn.symReqN = (pinOut.symReqOe ? pinOut.symReqN : 1'b1) & drv.symReqN;
  end

  fsb_host_agent #(.CfgCycles(4), .PriSettle(2), .AerrWin(4)) fsb_host_agent_inst (
    .core_clk(core_clk), .nrst(nrst), .regAddr(regAddr), .regWData(regWData), .regWr(regWr),
    .regRd(regRd), .regRData(regRData), .pinIn(pinIn), .pinOut(pinOut));

  fsb_cpu_model fsb_cpu_model_inst (
    .core_clk(core_clk), .host(pinOut), .bus(pinIn), .issue(issue), .reqAddr(reqAddr),
    .badPar(badPar), .stallOn(stallOn), .aerrOnHost(aerrOnHost), .bpSet(bpSet), .drv(drv),
    .cfgAddr(cfgAddr), .cfgSym(cfgSym), .seenAddr(seenAddr), .seenMisc(seenMisc),
    .adsCount(adsCount), .aerrSeen(aerrSeen), .binitSeen(binitSeen));

  // 100 MHz clock
  always #5 core_clk = ~core_clk;

  function automatic logic parLvl(input logic [32:0] l);
    return ~^(~l);
  endfunction

  task automatic wrReg(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWData <= d;
    @(posedge core_clk);
    regWr    <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rdReg(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd   <= 1'b0;
    #1 d = regRData;
  endtask

  task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic chkPin(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Bounded poll until neither busy nor pending
  task automatic waitIdle();
    int i;
    for (i = 0; i < 60; i++) begin
      rdReg(fsb_pkg::REG_STATUS, st);
      if (st[1:0] === 2'h0) break;
    end
    chkReg({30'h0, st[1:0]}, 32'h0);
  endtask

  task automatic pulseIssue(input logic [32:0] a, input logic bad);
    @(posedge core_clk);
    issue   <= 1'b1;
    reqAddr <= a;
    badPar  <= bad;
    @(posedge core_clk);
    issue   <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask

  task automatic summarize();
    if (n_mismatch == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial begin
    repeat (5000) @(posedge core_clk);
    n_mismatch++;
    summarize();
  end

  // Main sequence
  initial begin
    core_clk = 0; nrst = 0; regWr = 0; regRd = 0; regAddr = 4'h0; regWData = 32'h0;
    issue = 0; reqAddr = '0; badPar = 0; stallOn = 0; aerrOnHost = 0; bpSet = 4'h0;
    n_mismatch = 0; checked = 0;
    spd = '{2'h0, 2'h1, 2'h3};
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    waitIdle();
    rdReg(fsb_pkg::REG_CTRL, st); chkReg(st, 32'h0000_0103);
    rdReg(4'h7, st); chkReg(st, 32'h0);
    rdReg(fsb_pkg::REG_CMD, st); chkReg(st, 32'h0);
    // Straps seen by the processor after a restarted config phase
    wrReg(fsb_pkg::REG_STRAP, 32'h1234_5678);
    wrReg(fsb_pkg::REG_CMD, 32'h0000_0004);
    waitIdle();
    chkPin(cfgAddr, 33'h0_1234_5678);
    chkPin({32'h0, cfgSym}, 33'h1);
    for (int k = 0; k < 3; k++) begin
      wrReg(fsb_pkg::REG_CTRL, {22'h0, spd[k], 8'h03});
      @(posedge core_clk);
      #1 chkPin({31'h0, pinOut.speedSel}, {31'h0, spd[k]});
    end
    // Reserved speed refused, wrap mask taken
    wrReg(fsb_pkg::REG_CTRL, 32'h0000_0213);
    rdReg(fsb_pkg::REG_CTRL, st); chkReg(st, 32'h0000_0313);
    chkPin({32'h0, pinOut.wrapMaskN}, 33'h0);
    pulseIssue(33'h0_0002_0008, 1'b0);
    rdReg(fsb_pkg::REG_IN_ADDR, st); chkReg(st, 32'h0000_0040);
    wrReg(fsb_pkg::REG_CTRL, 32'h0000_0103);
    // Bad incoming parity: error pulse, then bus init when observe is off
    aS = aerrSeen; bS = binitSeen;
    pulseIssue(33'h0_0000_0001, 1'b1);
    rdReg(fsb_pkg::REG_STATUS, st); chkReg({31'h0, st[4]}, 32'h1);
    chkPin({25'h0, 8'(aerrSeen - aS)}, 33'h1);
    chkPin({25'h0, binitSeen}, {25'h0, bS});
    wrReg(fsb_pkg::REG_CMD, 32'h0000_0008);
    wrReg(fsb_pkg::REG_CTRL, 32'h0000_0102);
    pulseIssue(33'h0_0000_0001, 1'b1);
    chkPin({25'h0, 8'(binitSeen - bS)}, 33'h1);
    wrReg(fsb_pkg::REG_CTRL, 32'h0000_0103);
    waitIdle();
    // Host request: address, parity and request code on the strobe
    wrReg(fsb_pkg::REG_ADDR_LO, 32'h8765_4328);
    wrReg(fsb_pkg::REG_ADDR_HI, 32'h0000_1509);
    wrReg(fsb_pkg::REG_CMD, 32'h0000_0001);
    waitIdle();
    expA = {4'h9, 29'h10EC_A865};
    chkPin(seenAddr, expA);
    chkPin({24'h0, seenMisc}, {24'h0, 1'b1, parLvl({21'h1FFFFF, ~expA[32:21]}),
      parLvl({12'hFFF, ~expA[20:0]}), parLvl({28'hFFFFFFF, ~5'h15}), ~5'h15});
    // Stall holds the next request back
    @(posedge core_clk) stallOn <= 1'b1;
    repeat (6) @(posedge core_clk);
    c = adsCount;
    wrReg(fsb_pkg::REG_CMD, 32'h0000_0001);
    // Processor request held back too, so its ownership request stays up
    pulseIssue(33'h0_0000_0010, 1'b0);
    chkPin({25'h0, adsCount}, {25'h0, c});
    rdReg(fsb_pkg::REG_STATUS, st); chkReg({29'h0, st[5], st[2:1]}, 32'h7);
    @(posedge core_clk) stallOn <= 1'b0;
    waitIdle();
    chkPin({25'h0, adsCount}, {25'h0, 8'(c + 8'h01)});
    // Priority mode keeps the priority request low over the strobe
    wrReg(fsb_pkg::REG_CTRL, 32'h0000_0107);
    wrReg(fsb_pkg::REG_CMD, 32'h0000_0001);
    waitIdle();
    chkPin({32'h0, seenMisc[8]}, 33'h0);
    wrReg(fsb_pkg::REG_CTRL, 32'h0000_0103);
    // Parity error answer aborts the host request
    @(posedge core_clk) aerrOnHost <= 1'b1;
    wrReg(fsb_pkg::REG_CMD, 32'h0000_0001);
    waitIdle();
    chkReg({31'h0, st[3]}, 32'h1);
    @(posedge core_clk) aerrOnHost <= 1'b0;
    @(posedge core_clk) bpSet <= 4'hA;
    repeat (4) @(posedge core_clk);
    rdReg(fsb_pkg::REG_STATUS, st); chkReg({28'h0, st[9:6]}, 32'hA);
    // Own not-ready drive stalls the bus on the designated edges
    wrReg(fsb_pkg::REG_CTRL, 32'h0000_010B);
    repeat (6) @(posedge core_clk);
    rdReg(fsb_pkg::REG_STATUS, st); chkReg({31'h0, st[2]}, 32'h1);
    wrReg(fsb_pkg::REG_CTRL, 32'h0000_0103);
    // Forced bus init reaches the wire
    bS = binitSeen;
    wrReg(fsb_pkg::REG_CMD, 32'h0000_0002);
    repeat (6) @(posedge core_clk);
    chkPin({25'h0, 8'(binitSeen - bS)}, 33'h1);
    summarize();
  end
endmodule
`default_nettype wire
